// ===== common/mrid_pkg.sv
// constants, opcode encodings and register map for the instruction decoder
package mrid_pkg;

	// -------------------------------------------------------------------
	// word layout
	// -------------------------------------------------------------------
	localparam int unsigned IW_W          = 14;
	localparam int unsigned FA_W          = 7;
	localparam int unsigned BS_W          = 3;
	localparam int unsigned LIT8_W        = 8;
	localparam int unsigned LIT11_W       = 11;
	localparam int unsigned OSC_PER_CYCLE = 4;
	localparam int unsigned CLS_LSB       = 12;
	localparam int unsigned OPC_LSB       = 8;
	localparam int unsigned DEST_BIT      = 7;
	localparam int unsigned BSEL_LSB      = 7;
	localparam int unsigned BITOP_LSB     = 10;
	localparam int unsigned JUMP_BIT      = 11;

	// -------------------------------------------------------------------
	// class, opcode and fixed-word encodings
	// -------------------------------------------------------------------
	localparam logic [1:0] CLS_BYTE = 2'h0;
	localparam logic [1:0] CLS_BIT  = 2'h1;
	localparam logic [1:0] CLS_JUMP = 2'h2;
	localparam logic [3:0] BY_MISC = 4'h0;
	localparam logic [3:0] BY_CLR  = 4'h1;
	localparam logic [3:0] BY_SUB  = 4'h2;
	localparam logic [3:0] BY_DEC  = 4'h3;
	localparam logic [3:0] BY_OR   = 4'h4;
	localparam logic [3:0] BY_AND  = 4'h5;
	localparam logic [3:0] BY_XOR  = 4'h6;
	localparam logic [3:0] BY_ADD  = 4'h7;
	localparam logic [3:0] BY_MOV  = 4'h8;
	localparam logic [3:0] BY_COM  = 4'h9;
	localparam logic [3:0] BY_INC  = 4'ha;
	localparam logic [3:0] BY_DECS = 4'hb;
	localparam logic [3:0] BY_RRC  = 4'hc;
	localparam logic [3:0] BY_RLC  = 4'hd;
	localparam logic [3:0] BY_SWAP = 4'he;
	localparam logic [3:0] BY_INCS = 4'hf;
	localparam logic [1:0] LI_LOAD = 2'h0;
	localparam logic [1:0] LI_RET  = 2'h1;
	localparam logic [2:0] LI_SUB  = 3'h6;
	localparam logic [2:0] LI_ADD  = 3'h7;
	localparam logic [3:0] LI_OR   = 4'h8;
	localparam logic [3:0] LI_AND  = 4'h9;
	localparam logic [7:0] LOW_WDT   = 8'h64;
	localparam logic [7:0] LOW_SLEEP = 8'h63;
	localparam logic [7:0] LOW_RETI  = 8'h09;
	localparam logic [7:0] LOW_RET   = 8'h08;
	localparam logic [13:0] NOP_WORD = 14'h0000;

	// -------------------------------------------------------------------
	// register map and reset values
	// -------------------------------------------------------------------
	localparam int unsigned  BUS_AW       = 4;
	localparam logic [3:0]   REG_CTRL     = 4'h0;
	localparam logic [3:0]   REG_STATUS   = 4'h4;
	localparam logic [3:0]   REG_RETIRED  = 4'h8;
	localparam logic [3:0]   REG_TWOCYC   = 4'hc;
	localparam int unsigned  CTRL_RUN_BIT = 0;
	localparam logic         CTRL_RUN_RST = 1'h1;

	// -------------------------------------------------------------------
	// types
	// -------------------------------------------------------------------
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} mrid_phase_t;

	// file-register ops occupy 01..14 so one range test finds them
	typedef enum logic [5:0] {
		OP_NOP = 6'h00, OP_STORE_ACCUM = 6'h01, OP_CLEAR_FILE = 6'h02,
		OP_SUB_ACCUM_FILE = 6'h03, OP_DEC_FILE = 6'h04, OP_OR_ACCUM_FILE = 6'h05,
		OP_AND_ACCUM_FILE = 6'h06, OP_XOR_ACCUM_FILE = 6'h07,
		OP_ADD_ACCUM_FILE = 6'h08, OP_MOVE_FILE = 6'h09, OP_COMPL_FILE = 6'h0a,
		OP_INC_FILE = 6'h0b, OP_DECREMENT_SKIP_ZERO = 6'h0c,
		OP_ROTATE_RIGHT_CARRY = 6'h0d, OP_ROTATE_LEFT_CARRY = 6'h0e,
		OP_SWAP_NIBBLES = 6'h0f, OP_INCREMENT_SKIP_ZERO = 6'h10,
		OP_BIT_CLEAR_OP = 6'h11, OP_BIT_SET_OP = 6'h12,
		OP_TEST_SKIP_IF_CLEAR = 6'h13, OP_TEST_SKIP_IF_SET = 6'h14,
		OP_CLEAR_ACCUM = 6'h15, OP_CALL_SUB = 6'h16, OP_JUMP = 6'h17,
		OP_LOAD_LITERAL = 6'h18, OP_RETURN_WITH_LITERAL = 6'h19,
		OP_SUB_FROM_LITERAL = 6'h1a, OP_ADD_LITERAL = 6'h1b,
		OP_OR_LITERAL = 6'h1c, OP_AND_LITERAL = 6'h1d,
		OP_WATCHDOG_CLEAR_OP = 6'h1e, OP_STANDBY_OP = 6'h1f,
		OP_INTERRUPT_RETURN_OP = 6'h20, OP_SUB_RETURN_OP = 6'h21
	} mrid_op_t;

	localparam mrid_op_t FILE_FIRST = OP_STORE_ACCUM;
	localparam mrid_op_t BYTE_LAST  = OP_INCREMENT_SKIP_ZERO;
	localparam mrid_op_t FILE_LAST  = OP_TEST_SKIP_IF_SET;

endpackage

// ===== verilog/mrid_decoder.sv
// instruction decoder and four-phase sequencer for the 14-bit core
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

module mrid_decoder #(
	parameter int unsigned                INSTR_W    = 14,
	parameter int unsigned                CNT_W      = 16,
	parameter int unsigned                NUM_PORTS  = 2,
	parameter logic [NUM_PORTS*7-1:0]     PORT_ADDRS = {7'h07, 7'h05}
) (
	// clock, reset, enable
	input  wire logic                     core_clk,
	input  wire logic                     reset_n,
	input  wire logic                     clk_en,
	// program memory and datapath feedback
	input  wire logic [INSTR_W-1:0]       instr_word,
	input  wire logic                     result_zero,
	input  wire logic                     tested_bit,
	// register port
	input  wire logic [3:0]               bus_addr,
	input  wire logic [31:0]              bus_wdata,
	input  wire logic                     bus_wr,
	input  wire logic                     bus_rd,
	output logic      [31:0]              bus_rdata,
	// decoded fields
	output logic      [5:0]               op_code,
	output logic                          dest_file,
	output logic      [6:0]               file_addr,
	output logic      [2:0]               bit_sel,
	output logic      [7:0]               literal8,
	output logic      [10:0]              target11,
	// sequencing strobes
	output logic                          fetch,
	output logic                          file_rd,
	output logic                          pin_sel,
	output logic                          file_wr,
	output logic                          accum_wr,
	output logic                          pc_load,
	output logic                          stack_push,
	output logic                          stack_pop,
	output logic                          int_return,
	output logic                          nop_cycle,
	// flag and power control
	output logic                          upd_carry,
	output logic                          upd_digit_carry,
	output logic                          upd_zero,
	output logic                          watchdog_clear,
	output logic                          standby_req,
	output logic                          upd_wdt_flags
);

	// -------------------------------------------------------------------
	// parameter checks
	// -------------------------------------------------------------------
	if (INSTR_W != mrid_pkg::IW_W) begin : g_bad_iw
		$error("instruction width must be 14");
	end
	if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
		$error("counter width must be 1 to 32");
	end
	if (NUM_PORTS < 1) begin : g_bad_ports
		$error("at least one port address required");
	end

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	typedef struct packed {
		mrid_pkg::mrid_phase_t  phase;
		mrid_pkg::mrid_op_t     op;
		logic [13:0]            iw;
		logic                   dest_file;
		logic [6:0]             file_addr;
		logic [2:0]             bit_sel;
		logic [10:0]            literal;
		logic                   run;
		logic                   taken;
		logic                   flush;
		logic                   nop_cycle;
		logic                   fetch;
		logic                   file_rd;
		logic                   pin_sel;
		logic                   file_wr;
		logic                   accum_wr;
		logic                   pc_load;
		logic                   stack_push;
		logic                   stack_pop;
		logic                   int_return;
		logic                   upd_carry;
		logic                   upd_digit_carry;
		logic                   upd_zero;
		logic                   watchdog_clear;
		logic                   standby_req;
		logic                   upd_wdt_flags;
		logic [CNT_W-1:0]       retired;
		logic [CNT_W-1:0]       twocyc;
		logic [31:0]            rdata;
	} mrid_state_t;

	localparam mrid_state_t RESET_STATE = '{
		phase:   mrid_pkg::PH_Q1,
		op:      mrid_pkg::OP_NOP,
		run:     mrid_pkg::CTRL_RUN_RST,
		default: '0
	};

	mrid_state_t s;
	mrid_state_t next_s;

	// -------------------------------------------------------------------
	// decode helpers
	// -------------------------------------------------------------------
	// only the bits that the encodings fix are compared
	function automatic mrid_pkg::mrid_op_t decode_op(input logic [13:0] w);
		mrid_pkg::mrid_op_t o;
		logic [3:0]         opc;
		o   = mrid_pkg::OP_NOP;
		opc = w[mrid_pkg::OPC_LSB +: 4];
		case (w[mrid_pkg::CLS_LSB +: 2])
			mrid_pkg::CLS_BYTE: begin
				case (opc)
					mrid_pkg::BY_MISC: begin
						if (w[mrid_pkg::DEST_BIT])
							o = mrid_pkg::OP_STORE_ACCUM;
						else if (w[7:0] == mrid_pkg::LOW_WDT)
							o = mrid_pkg::OP_WATCHDOG_CLEAR_OP;
						else if (w[7:0] == mrid_pkg::LOW_SLEEP)
							o = mrid_pkg::OP_STANDBY_OP;
						else if (w[7:0] == mrid_pkg::LOW_RETI)
							o = mrid_pkg::OP_INTERRUPT_RETURN_OP;
						else if (w[7:0] == mrid_pkg::LOW_RET)
							o = mrid_pkg::OP_SUB_RETURN_OP;
						else
							o = mrid_pkg::OP_NOP;
					end
					mrid_pkg::BY_CLR: begin
						if (w[mrid_pkg::DEST_BIT])
							o = mrid_pkg::OP_CLEAR_FILE;
						else
							o = mrid_pkg::OP_CLEAR_ACCUM;
					end
					mrid_pkg::BY_ADD:  o = mrid_pkg::OP_ADD_ACCUM_FILE;
					mrid_pkg::BY_AND:  o = mrid_pkg::OP_AND_ACCUM_FILE;
					mrid_pkg::BY_OR:   o = mrid_pkg::OP_OR_ACCUM_FILE;
					mrid_pkg::BY_XOR:  o = mrid_pkg::OP_XOR_ACCUM_FILE;
					mrid_pkg::BY_SUB:  o = mrid_pkg::OP_SUB_ACCUM_FILE;
					mrid_pkg::BY_RLC:  o = mrid_pkg::OP_ROTATE_LEFT_CARRY;
					mrid_pkg::BY_RRC:  o = mrid_pkg::OP_ROTATE_RIGHT_CARRY;
					mrid_pkg::BY_DECS: o = mrid_pkg::OP_DECREMENT_SKIP_ZERO;
					mrid_pkg::BY_INCS: o = mrid_pkg::OP_INCREMENT_SKIP_ZERO;
					mrid_pkg::BY_DEC:  o = mrid_pkg::OP_DEC_FILE;
					mrid_pkg::BY_INC:  o = mrid_pkg::OP_INC_FILE;
					mrid_pkg::BY_MOV:  o = mrid_pkg::OP_MOVE_FILE;
					mrid_pkg::BY_COM:  o = mrid_pkg::OP_COMPL_FILE;
					default:           o = mrid_pkg::OP_SWAP_NIBBLES;
				endcase
			end
			mrid_pkg::CLS_BIT: begin
				case (w[mrid_pkg::BITOP_LSB +: 2])
					2'h0:    o = mrid_pkg::OP_BIT_CLEAR_OP;
					2'h1:    o = mrid_pkg::OP_BIT_SET_OP;
					2'h2:    o = mrid_pkg::OP_TEST_SKIP_IF_CLEAR;
					default: o = mrid_pkg::OP_TEST_SKIP_IF_SET;
				endcase
			end
			mrid_pkg::CLS_JUMP: begin
				if (w[mrid_pkg::JUMP_BIT])
					o = mrid_pkg::OP_JUMP;
				else
					o = mrid_pkg::OP_CALL_SUB;
			end
			default: begin
				// literal class: low code bits marked x are not compared
				if (opc[3:2] == mrid_pkg::LI_LOAD)
					o = mrid_pkg::OP_LOAD_LITERAL;
				else if (opc[3:2] == mrid_pkg::LI_RET)
					o = mrid_pkg::OP_RETURN_WITH_LITERAL;
				else if (opc[3:1] == mrid_pkg::LI_ADD)
					o = mrid_pkg::OP_ADD_LITERAL;
				else if (opc[3:1] == mrid_pkg::LI_SUB)
					o = mrid_pkg::OP_SUB_FROM_LITERAL;
				else if (opc == mrid_pkg::LI_OR)
					o = mrid_pkg::OP_OR_LITERAL;
				else if (opc == mrid_pkg::LI_AND)
					o = mrid_pkg::OP_AND_LITERAL;
				else
					o = mrid_pkg::OP_NOP;
			end
		endcase
		return o;
	endfunction

	function automatic logic is_file_op(input mrid_pkg::mrid_op_t o);
		return o >= mrid_pkg::FILE_FIRST && o <= mrid_pkg::FILE_LAST;
	endfunction

	function automatic logic is_byte_op(input mrid_pkg::mrid_op_t o);
		return o >= mrid_pkg::FILE_FIRST && o <= mrid_pkg::BYTE_LAST;
	endfunction

	function automatic logic is_accum_lit(input mrid_pkg::mrid_op_t o);
		return o >= mrid_pkg::OP_LOAD_LITERAL && o <= mrid_pkg::OP_AND_LITERAL;
	endfunction

	// -------------------------------------------------------------------
	// port address match
	// -------------------------------------------------------------------
	logic [NUM_PORTS-1:0] port_hit;

	for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
		assign port_hit[i] = (s.file_addr == PORT_ADDRS[i*mrid_pkg::FA_W +: mrid_pkg::FA_W]);
	end

	// -------------------------------------------------------------------
	// next state
	// -------------------------------------------------------------------
	always_comb begin
		logic [13:0]        word;
		mrid_pkg::mrid_op_t dop;
		logic               clr_ret;
		logic               clr_two;
		word    = mrid_pkg::NOP_WORD;
		dop     = mrid_pkg::OP_NOP;
		clr_ret = 1'b0;
		clr_two = 1'b0;
		next_s  = s;
		if (clk_en) begin
			// strobes last one clock
			next_s.fetch           = 1'b0;
			next_s.file_rd         = 1'b0;
			next_s.pin_sel         = 1'b0;
			next_s.file_wr         = 1'b0;
			next_s.accum_wr        = 1'b0;
			next_s.pc_load         = 1'b0;
			next_s.stack_push      = 1'b0;
			next_s.stack_pop       = 1'b0;
			next_s.int_return      = 1'b0;
			next_s.upd_carry       = 1'b0;
			next_s.upd_digit_carry = 1'b0;
			next_s.upd_zero        = 1'b0;
			next_s.watchdog_clear  = 1'b0;
			next_s.standby_req     = 1'b0;
			next_s.upd_wdt_flags   = 1'b0;
			next_s.rdata           = '0;

			// register port
			if (bus_rd) begin
				if (bus_addr == mrid_pkg::REG_CTRL)
					next_s.rdata = {31'h0, s.run};
				else if (bus_addr == mrid_pkg::REG_STATUS)
					next_s.rdata = {6'h0, s.iw, s.phase, s.flush, s.nop_cycle, s.op};
				else if (bus_addr == mrid_pkg::REG_RETIRED)
					next_s.rdata = 32'(s.retired);
				else if (bus_addr == mrid_pkg::REG_TWOCYC)
					next_s.rdata = 32'(s.twocyc);
				else
					next_s.rdata = '0;
			end
			if (bus_wr) begin
				if (bus_addr == mrid_pkg::REG_CTRL)
					next_s.run = bus_wdata[mrid_pkg::CTRL_RUN_BIT];
				else if (bus_addr == mrid_pkg::REG_RETIRED)
					clr_ret = 1'b1;
				else if (bus_addr == mrid_pkg::REG_TWOCYC)
					clr_two = 1'b1;
			end
			if (clr_ret)
				next_s.retired = '0;
			if (clr_two)
				next_s.twocyc = '0;

			// four clock periods make one instruction cycle
			case (s.phase)
				mrid_pkg::PH_Q1: begin
					// a flushed or halted cycle executes as a no-op
					if (!s.flush && s.run)
						word = instr_word;
					dop                = decode_op(word);
					next_s.iw          = word;
					next_s.op          = dop;
					next_s.nop_cycle   = s.flush;
					next_s.flush       = 1'b0;
					next_s.taken       = 1'b0;
					next_s.file_addr   = word[mrid_pkg::FA_W-1:0];
					next_s.dest_file   = word[mrid_pkg::DEST_BIT];
					next_s.bit_sel     = word[mrid_pkg::BSEL_LSB +: mrid_pkg::BS_W];
					next_s.literal     = word[mrid_pkg::LIT11_W-1:0];
					next_s.phase       = mrid_pkg::PH_Q2;
				end
				mrid_pkg::PH_Q2: begin
					// read happens even when the op only writes
					next_s.file_rd = is_file_op(s.op);
					next_s.pin_sel = is_file_op(s.op) && (|port_hit);
					next_s.phase   = mrid_pkg::PH_Q3;
				end
				mrid_pkg::PH_Q3: begin
					case (s.op)
						mrid_pkg::OP_ADD_ACCUM_FILE, mrid_pkg::OP_SUB_ACCUM_FILE,
						mrid_pkg::OP_ADD_LITERAL, mrid_pkg::OP_SUB_FROM_LITERAL: begin
							next_s.upd_carry       = 1'b1;
							next_s.upd_digit_carry = 1'b1;
							next_s.upd_zero        = 1'b1;
						end
						mrid_pkg::OP_ROTATE_LEFT_CARRY, mrid_pkg::OP_ROTATE_RIGHT_CARRY: begin
							next_s.upd_carry = 1'b1;
						end
						mrid_pkg::OP_AND_ACCUM_FILE, mrid_pkg::OP_OR_ACCUM_FILE,
						mrid_pkg::OP_XOR_ACCUM_FILE, mrid_pkg::OP_CLEAR_FILE,
						mrid_pkg::OP_CLEAR_ACCUM, mrid_pkg::OP_COMPL_FILE,
						mrid_pkg::OP_DEC_FILE, mrid_pkg::OP_INC_FILE,
						mrid_pkg::OP_MOVE_FILE, mrid_pkg::OP_AND_LITERAL,
						mrid_pkg::OP_OR_LITERAL: begin
							next_s.upd_zero = 1'b1;
						end
						mrid_pkg::OP_WATCHDOG_CLEAR_OP: begin
							next_s.watchdog_clear = 1'b1;
							next_s.upd_wdt_flags  = 1'b1;
						end
						mrid_pkg::OP_STANDBY_OP: begin
							next_s.standby_req   = 1'b1;
							next_s.upd_wdt_flags = 1'b1;
						end
						mrid_pkg::OP_DECREMENT_SKIP_ZERO, mrid_pkg::OP_INCREMENT_SKIP_ZERO: begin
							next_s.taken = result_zero;
						end
						mrid_pkg::OP_TEST_SKIP_IF_CLEAR: begin
							next_s.taken = !tested_bit;
						end
						mrid_pkg::OP_TEST_SKIP_IF_SET: begin
							next_s.taken = tested_bit;
						end
						mrid_pkg::OP_CALL_SUB: begin
							next_s.taken      = 1'b1;
							next_s.pc_load    = 1'b1;
							next_s.stack_push = 1'b1;
						end
						mrid_pkg::OP_JUMP: begin
							next_s.taken   = 1'b1;
							next_s.pc_load = 1'b1;
						end
						mrid_pkg::OP_RETURN_WITH_LITERAL, mrid_pkg::OP_SUB_RETURN_OP: begin
							next_s.taken     = 1'b1;
							next_s.pc_load   = 1'b1;
							next_s.stack_pop = 1'b1;
						end
						mrid_pkg::OP_INTERRUPT_RETURN_OP: begin
							next_s.taken      = 1'b1;
							next_s.pc_load    = 1'b1;
							next_s.stack_pop  = 1'b1;
							next_s.int_return = 1'b1;
						end
						default: begin
							next_s.taken = 1'b0;
						end
					endcase
					next_s.phase = mrid_pkg::PH_Q4;
				end
				mrid_pkg::PH_Q4: begin
					// result goes to accumulator or back to the file register
					next_s.file_wr = (is_byte_op(s.op) && s.dest_file)
						|| s.op == mrid_pkg::OP_BIT_CLEAR_OP
						|| s.op == mrid_pkg::OP_BIT_SET_OP;
					next_s.accum_wr = (is_byte_op(s.op) && !s.dest_file)
						|| s.op == mrid_pkg::OP_CLEAR_ACCUM
						|| is_accum_lit(s.op);
					next_s.flush = s.taken;
					next_s.fetch = 1'b1;
					if (!s.nop_cycle)
						next_s.retired = (clr_ret ? '0 : s.retired) + 1'b1;
					if (s.taken)
						next_s.twocyc = (clr_two ? '0 : s.twocyc) + 1'b1;
					next_s.phase = mrid_pkg::PH_Q1;
				end
				default: begin
					next_s.phase = mrid_pkg::PH_Q1;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!reset_n)
			s <= RESET_STATE;
		else
			s <= next_s;
	end

	// -------------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------------
	assign bus_rdata       = s.rdata;
	assign op_code         = s.op;
	assign dest_file       = s.dest_file;
	assign file_addr       = s.file_addr;
	assign bit_sel         = s.bit_sel;
	assign literal8        = s.literal[mrid_pkg::LIT8_W-1:0];
	assign target11        = s.literal;
	assign fetch           = s.fetch;
	assign file_rd         = s.file_rd;
	assign pin_sel         = s.pin_sel;
	assign file_wr         = s.file_wr;
	assign accum_wr        = s.accum_wr;
	assign pc_load         = s.pc_load;
	assign stack_push      = s.stack_push;
	assign stack_pop       = s.stack_pop;
	assign int_return      = s.int_return;
	assign nop_cycle       = s.nop_cycle;
	assign upd_carry       = s.upd_carry;
	assign upd_digit_carry = s.upd_digit_carry;
	assign upd_zero        = s.upd_zero;
	assign watchdog_clear  = s.watchdog_clear;
	assign standby_req     = s.standby_req;
	assign upd_wdt_flags   = s.upd_wdt_flags;

endmodule

`default_nettype wire

// ===== tb/mrid_decoder_asserts.sv
// concurrent checks on the instruction decoder ports
`timescale 1ns/1ps
`default_nettype none
module mrid_decoder_asserts #(
	parameter logic [13:0] PORT_ADDRS = {7'h07, 7'h05}
) (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       reset_n,
	// decoded fields
	input wire logic [5:0] op_code,
	input wire logic       dest_file,
	input wire logic [6:0] file_addr,
	input wire logic       nop_cycle,
	// strobes
	input wire logic       fetch,
	input wire logic       file_rd,
	input wire logic       pin_sel,
	input wire logic       file_wr,
	input wire logic       accum_wr,
	input wire logic       pc_load,
	input wire logic       stack_pop,
	input wire logic       int_return,
	input wire logic       upd_carry,
	input wire logic       upd_digit_carry,
	input wire logic       upd_zero,
	input wire logic       watchdog_clear,
	input wire logic       standby_req,
	input wire logic       upd_wdt_flags
);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_cycle; fetch |=> !fetch [*3] ##1 fetch; endproperty
	a_cycle: assert property (p_cycle) else $error("fetch period wrong");
	property p_rmw; file_wr |-> $past(file_rd, 2); endproperty
	a_rmw: assert property (p_rmw) else $error("write without read");
	property p_pin;
		pin_sel == (file_rd && (file_addr == PORT_ADDRS[6:0] || file_addr == PORT_ADDRS[13:7]));
	endproperty
	a_pin: assert property (p_pin) else $error("pin select wrong");
	property p_dest;
		(file_wr || accum_wr) && op_code >= 6'h01 && op_code <= 6'h10 |-> file_wr == dest_file;
	endproperty
	a_dest: assert property (p_dest) else $error("destination wrong");
	property p_flush; pc_load |-> ##2 nop_cycle [*4]; endproperty
	a_flush: assert property (p_flush) else $error("branch not flushed");
	property p_pop; stack_pop |-> ##2 nop_cycle [*4]; endproperty
	a_pop: assert property (p_pop) else $error("return not two cycles");
	property p_quiet; nop_cycle |-> op_code == 6'h00 && !file_rd && !file_wr && !accum_wr; endproperty
	a_quiet: assert property (p_quiet) else $error("flushed cycle active");
	property p_wdt; upd_wdt_flags == (watchdog_clear || standby_req); endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog flags wrong");
	property p_dc; upd_digit_carry |-> upd_carry && upd_zero; endproperty
	a_dc: assert property (p_dc) else $error("flag set wrong");
	property p_rot; upd_carry && !upd_zero |-> op_code inside {6'h0d, 6'h0e}; endproperty
	a_rot: assert property (p_rot) else $error("carry only wrong");
	property p_reti; int_return |-> stack_pop; endproperty
	a_reti: assert property (p_reti) else $error("interrupt return wrong");
	c_skip: cover property ($rose(nop_cycle));
	c_pin: cover property (pin_sel);
	c_sleep: cover property (standby_req);
	c_reti: cover property (int_return);
endmodule
bind mrid_decoder mrid_decoder_asserts #(.PORT_ADDRS(PORT_ADDRS)) u_mrid_decoder_asserts (.*);
`default_nettype wire

// ===== tb/tb.sv
// random and corner stimulus for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ----------------------------------------------------------------
	// signals and design
	// ----------------------------------------------------------------
	logic        core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
	logic        result_zero = 1'b0, tested_bit = 1'b0, flush = 1'b0, run = 1'b1;
	logic [13:0] instr_word = 14'h0000;
	logic [3:0]  bus_addr = 4'h0;
	logic [31:0] bus_wdata = 32'h0, bus_rdata, r;
	logic [29:0] wx = 30'h0;
	logic        pend = 1'b0;
	logic [5:0]  op_code;
	logic [6:0]  file_addr;
	logic [2:0]  bit_sel;
	logic [7:0]  literal8;
	logic [10:0] target11;
	logic        dest_file, fetch, file_rd, pin_sel, file_wr, accum_wr, pc_load, stack_push;
	logic        stack_pop, int_return, nop_cycle, upd_carry, upd_digit_carry, upd_zero;
	logic        watchdog_clear, standby_req, upd_wdt_flags;
	int          failures = 0, cmp_count = 0, ph = 0, taken = 0, seed = 32'hfb41;
	// low 14 bits word, bit 15 result zero, bit 14 tested bit
	logic [15:0] corner [$] = {16'h0785, 16'h0507, 16'h0420, 16'h06a0, 16'h0201, 16'h0d85,
		16'h0c05, 16'h8b10, 16'h0b10, 16'h8f10, 16'h1385, 16'h1785, 16'h1b05, 16'h5b05,
		16'h5f05, 16'h1f05, 16'h3e55, 16'h3955, 16'h3855, 16'h3c55, 16'h3355, 16'h3755,
		16'h2123, 16'h2823, 16'h0064, 16'h0063, 16'h0009, 16'h0008, 16'h0060, 16'h017f,
		16'h0190, 16'h00a5, 16'h3a11, 16'h0e12, 16'h0912, 16'h0312, 16'h0a12, 16'h0812};
	mrid_decoder u_mrid_decoder (.*);
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) ph <= reset_n ? ph + 1 : 0;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] exp, got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [5:0] dec(input logic [13:0] w);
		case (w[13:12])
			2'h0: begin
				if (w[11:8] > 4'h1 || w[7])
					return {2'h0, w[11:8]} + 6'h01;
				if (w[11:8] == 4'h1)
					return 6'h15;
				case (w[7:0])
					8'h64: return 6'h1e;
					8'h63: return 6'h1f;
					8'h09: return 6'h20;
					8'h08: return 6'h21;
					default: return 6'h00;
				endcase
			end
			2'h1: return 6'h11 + {4'h0, w[11:10]};
			2'h2: return w[11] ? 6'h17 : 6'h16;
			default: casez (w[11:8])
				4'b00??: return 6'h18;
				4'b01??: return 6'h19;
				4'b110?: return 6'h1a;
				4'b111?: return 6'h1b;
				4'b1000: return 6'h1c;
				4'b1001: return 6'h1d;
				default: return 6'h00;
			endcase
		endcase
	endfunction
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, exp);
		@(posedge core_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= wr;
		bus_rd <= !wr;
		@(posedge core_clk);
		bus_wr <= 1'b0;
		bus_rd <= 1'b0;
		@(negedge core_clk);
		if (!wr)
			chk("bus_rdata", exp, bus_rdata);
	endtask
	// one instruction cycle, checked phase by phase
	task automatic exec(input logic [13:0] w, input logic rz, tbit);
		logic [13:0] e;
		logic [5:0]  op;
		logic [29:0] f, x;
		logic        by, cdz, pj, tk;
		// drive on the edge just before the word is latched
		do
			@(posedge core_clk);
		while (ph % 4 != 3);
		instr_word <= w;
		result_zero <= rz;
		tested_bit <= tbit;
		e = (flush || !run) ? 14'h0000 : w;
		op = dec(e);
		by = op >= 6'h01 && op <= 6'h10;
		cdz = op inside {6'h03, 6'h08, 6'h1a, 6'h1b};
		pj = op inside {6'h16, 6'h17, 6'h19, 6'h20, 6'h21};
		tk = pj || (op inside {6'h0c, 6'h10} && rz) || (op == 6'h13 && !tbit) || (op == 6'h14 && tbit);
		@(negedge core_clk);
		if (pend)
			chk("writes", wx, 30'({fetch, file_wr, accum_wr}));
		@(negedge core_clk);
		chk("op_code", op, op_code);
		chk("nop_cycle", flush, nop_cycle);
		f = {dest_file, file_addr, bit_sel, literal8, target11};
		chk("fields", {e[7], e[6:0], e[9:7], e[7:0], e[10:0]}, f);
		@(negedge core_clk);
		chk("file_rd", {op >= 6'h01 && op <= 6'h14, 1'b0}, {file_rd, 1'b0});
		chk("pin_sel", op >= 6'h01 && op <= 6'h14 && e[6:0] inside {7'h05, 7'h07}, pin_sel);
		@(negedge core_clk);
		x = 30'({cdz || op inside {6'h0d, 6'h0e}, cdz, cdz || op inside {6'h02, 6'h04, 6'h05,
			6'h06, 6'h07, 6'h09, 6'h0a, 6'h0b, 6'h15, 6'h1c, 6'h1d}, pj, op == 6'h16,
			pj && op > 6'h17, op == 6'h20, op == 6'h1e, op == 6'h1f, op inside {6'h1e, 6'h1f}});
		f = 30'({upd_carry, upd_digit_carry, upd_zero, pc_load, stack_push, stack_pop,
			int_return, watchdog_clear, standby_req, upd_wdt_flags});
		chk("pulses", x, f);
		// writes and fetch appear after the last edge, checked by the next call
		wx = 30'({1'b1, (by && e[7]) || op inside {6'h11, 6'h12},
			(by && !e[7]) || op inside {6'h15, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d}});
		pend = 1'b1;
		flush = tk;
		taken += int'(tk);
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge core_clk);
		reset_n <= 1'b1;
		bus(1'b0, mrid_pkg::REG_CTRL, 32'h0, 32'h1);
		bus(1'b0, mrid_pkg::REG_TWOCYC, 32'h0, 32'h0);
		bus(1'b0, 4'h2, 32'h0, 32'h0);
		foreach (corner[i])
			exec(corner[i][13:0], corner[i][15], corner[i][14]);
		repeat (300) begin
			r = $random(seed);
			exec(r[13:0], r[14], r[15]);
		end
		exec(14'h0000, 1'b0, 1'b0);
		bus(1'b0, mrid_pkg::REG_TWOCYC, 32'h0, taken);
		bus(1'b1, mrid_pkg::REG_TWOCYC, 32'h0, 32'h0);
		bus(1'b0, mrid_pkg::REG_TWOCYC, 32'h0, 32'h0);
		bus(1'b1, mrid_pkg::REG_CTRL, 32'h0, 32'h0);
		run = 1'b0;
		exec(14'h2123, 1'b0, 1'b0);
		bus(1'b1, mrid_pkg::REG_CTRL, 32'h1, 32'h0);
		report_and_stop();
	end
	initial begin
		#20000;
		failures++;
		report_and_stop();
	end
endmodule
`default_nettype wire
